// [common/amir_map.vh]
// Register map and constants of the memory-interface interrupt mask block
//
// Overview of operation
// - A newly set masked status bit sends a one-cycle high pulse to the CPU.
// - Wait-rise masked bit 2 sets on a wait rising edge when enabled.
// - Timeout masked bit 0 sets when wait outlasts the maximum count, if enabled.
// - Writing one clears a masked status bit; writing zero leaves it.
// - Write-one clearing of a masked bit also clears its raw status twin; disabling the event leaves raw set.
// - In the status and enable registers, bits 31-3 and 1 read zero; software writes zero there.
// - Writing one to an enable-set bit sets it and its clear mirror.
// - Enable bits clear only through the companion enable-clear register.
// - A disabled event keeps its masked bit at zero and gives no pulse.
// - Raw status bits set on their events regardless of enables.
// - Writing one to an enable-clear bit disables the event and both mirrors.
`ifndef AMIR_MAP_VH
`define AMIR_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define AMIR_OFS_RAW      12'h000
`define AMIR_OFS_MASKED   12'h004
`define AMIR_OFS_EN_SET   12'h008
`define AMIR_OFS_EN_CLR   12'h00c
`define AMIR_OFS_WAIT_CFG 12'h010
`define AMIR_OFS_LEVEL    12'h014

// ****************************************
// Field positions and widths
// ****************************************
`define AMIR_BIT_TIMEOUT  0
`define AMIR_BIT_WRISE    2
`define AMIR_EVT_W        3
`define AMIR_EVT_MASK     3'h5
`define AMIR_CNT_W        8
`define AMIR_ADDR_W       12

// ****************************************
// Reset values
// ****************************************
`define AMIR_RST_EVT      3'h0
`define AMIR_RST_CNT      8'h80
`define AMIR_ZERO32       32'h0000_0000

`endif

// [rtl/amir_timeout_cnt.v]
// Extended-wait timeout counter of the interrupt mask block
`timescale 1ns/1ps
`include "amir_map.vh"
module amir_timeout_cnt #(
  parameter CNT_W = `AMIR_CNT_W
) (
  // Clock and reset
  input  wire             i_ref_clk,
  input  wire             i_rst_n,
  // Wait level and limit
  input  wire             i_wait_act,
  input  wire [CNT_W-1:0] i_max_count,
  // Event
  output reg              o_timeout
);

  reg [CNT_W-1:0] cnt_r;
  reg             fired_r;

  // ****************************************
  // Counter
  // ****************************************
  // Fires once per wait episode so one long wait gives one event
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cnt_r     <= {CNT_W{1'b0}};
      fired_r   <= 1'b0;
      o_timeout <= 1'b0;
    end else if (!i_wait_act) begin
      cnt_r     <= {CNT_W{1'b0}};
      fired_r   <= 1'b0;
      o_timeout <= 1'b0;
    end else begin
      if (!fired_r && cnt_r >= i_max_count) begin
        fired_r   <= 1'b1;
        o_timeout <= 1'b1;
      end else begin
        o_timeout <= 1'b0;
      end
      if (!fired_r) begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [rtl/amir_irq_mask.v]
// Interrupt mask and status logic with APB register access
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "amir_map.vh"
module amir_irq_mask #(
  parameter CNT_W  = `AMIR_CNT_W,
  parameter ADDR_W = `AMIR_ADDR_W
) (
  // Clock and reset
  input  wire              i_ref_clk,
  input  wire              i_rst_n,
  // APB slave
  input  wire              i_psel,
  input  wire              i_penable,
  input  wire              i_pwrite,
  input  wire [ADDR_W-1:0] i_paddr,
  input  wire [31:0]       i_pwdata,
  output reg  [31:0]       o_prdata,
  output reg               o_pready,
  output reg               o_pslverr,
  // External wait pin
  input  wire              i_ext_wait_in,
  // Interrupts
  output reg               o_irq_pulse,
  output reg               o_irq
);

  localparam EW = `AMIR_EVT_W;

  // ****************************************
  // State
  // ****************************************
  reg  [EW-1:0]    raw_r;
  reg  [EW-1:0]    raw_nxt;
  reg  [EW-1:0]    masked_r;
  reg  [EW-1:0]    masked_nxt;
  reg  [EW-1:0]    enable_r;
  reg  [EW-1:0]    enable_nxt;
  reg  [CNT_W-1:0] max_cnt_r;
  reg              wait_s1_r;
  reg              wait_s2_r;
  reg              wait_d_r;
  wire             timeout_evt;
  wire [EW-1:0]    evt;
  wire             wr_acc;
  wire             rd_acc;
  wire [EW-1:0]    wbits;
  wire             hit;

  // Only valid event bits; reserved bits never stored
  function [EW-1:0] evt_bits;
    input [31:0] d;
    begin
      evt_bits = d[EW-1:0] & `AMIR_EVT_MASK;
    end
  endfunction

  // Decode used by both the write and the read path
  function is_reg;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ofs;
    begin
      is_reg = (a == ofs);
    end
  endfunction

  // ****************************************
  // Wait pin synchroniser
  // ****************************************
  // two flops first
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wait_s1_r <= 1'b0;
      wait_s2_r <= 1'b0;
      wait_d_r  <= 1'b0;
    end else begin
      wait_s1_r <= i_ext_wait_in;
      wait_s2_r <= wait_s1_r;
      wait_d_r  <= wait_s2_r;
    end
  end

  amir_timeout_cnt #(
    .CNT_W (CNT_W)
  ) u_tmo (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_wait_act  (wait_s2_r),
    .i_max_count (max_cnt_r),
    .o_timeout   (timeout_evt)
  );

  assign evt[`AMIR_BIT_WRISE]   = wait_s2_r & ~wait_d_r;
  assign evt[1]                 = 1'b0;
  assign evt[`AMIR_BIT_TIMEOUT] = timeout_evt;

  // ****************************************
  // Bus decode
  // ****************************************
  // Zero wait state: access phase completes at once
  assign wr_acc = i_psel & i_penable & i_pwrite;
  assign rd_acc = i_psel & ~i_penable & ~i_pwrite;
  assign wbits  = evt_bits(i_pwdata);
  assign hit    = is_reg(i_paddr, `AMIR_OFS_RAW)
                | is_reg(i_paddr, `AMIR_OFS_MASKED)
                | is_reg(i_paddr, `AMIR_OFS_EN_SET)
                | is_reg(i_paddr, `AMIR_OFS_EN_CLR)
                | is_reg(i_paddr, `AMIR_OFS_WAIT_CFG)
                | is_reg(i_paddr, `AMIR_OFS_LEVEL);

  // ****************************************
  // Next-state logic
  // ****************************************
  always @* begin
    raw_nxt    = raw_r;
    masked_nxt = masked_r;
    enable_nxt = enable_r;
    if (wr_acc) begin
      if (is_reg(i_paddr, `AMIR_OFS_EN_SET)) begin
        enable_nxt = enable_r | wbits;
      end
      if (is_reg(i_paddr, `AMIR_OFS_EN_CLR)) begin
        enable_nxt = enable_r & ~wbits;
      end
      if (is_reg(i_paddr, `AMIR_OFS_MASKED) ||
          is_reg(i_paddr, `AMIR_OFS_RAW)) begin
        masked_nxt = masked_r & ~wbits;
        raw_nxt    = raw_r & ~wbits;
      end
    end
    raw_nxt    = raw_nxt | evt;
    masked_nxt = masked_nxt | (evt & enable_nxt);
    masked_nxt = masked_nxt & enable_nxt;
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      raw_r     <= `AMIR_RST_EVT;
      masked_r  <= `AMIR_RST_EVT;
      enable_r  <= `AMIR_RST_EVT;
      max_cnt_r <= `AMIR_RST_CNT;
    end else begin
      raw_r    <= raw_nxt & `AMIR_EVT_MASK;
      masked_r <= masked_nxt & `AMIR_EVT_MASK;
      enable_r <= enable_nxt & `AMIR_EVT_MASK;
      if (wr_acc && is_reg(i_paddr, `AMIR_OFS_WAIT_CFG)) begin
        max_cnt_r <= i_pwdata[CNT_W-1:0];
      end
    end
  end

  // ****************************************
  // Read path and response
  // ****************************************
  // reserved bits read zero
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_prdata  <= `AMIR_ZERO32;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      // Registered answer: ready in the first cycle of the access phase
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~hit;
      o_prdata  <= `AMIR_ZERO32;
      if (rd_acc) begin
        if (is_reg(i_paddr, `AMIR_OFS_RAW)) begin
          o_prdata <= {{(32-EW){1'b0}}, raw_r};
        end
        if (is_reg(i_paddr, `AMIR_OFS_MASKED)) begin
          o_prdata <= {{(32-EW){1'b0}}, masked_r};
        end
        if (is_reg(i_paddr, `AMIR_OFS_EN_SET) ||
            is_reg(i_paddr, `AMIR_OFS_EN_CLR)) begin
          o_prdata <= {{(32-EW){1'b0}}, enable_r};
        end
        if (is_reg(i_paddr, `AMIR_OFS_WAIT_CFG)) begin
          o_prdata <= {{(32-CNT_W){1'b0}}, max_cnt_r};
        end
        if (is_reg(i_paddr, `AMIR_OFS_LEVEL)) begin
          o_prdata <= {31'h0000_0000, o_irq};
        end
      end
    end
  end

  // ****************************************
  // Interrupt outputs
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_irq_pulse <= 1'b0;
      o_irq       <= 1'b0;
    end else begin
      o_irq_pulse <= |(masked_nxt & ~masked_r);
      o_irq       <= |masked_nxt;
    end
  end

endmodule

// [tb/amir_irq_mask_sva.sv]
// Assertion checker of the interrupt mask block
`timescale 1ns/1ps
module amir_irq_mask_sva #(
  parameter ADDR_W = 12
) (
  input wire logic              i_ref_clk,
  input wire logic              i_rst_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic              i_ext_wait_in,
  input wire logic              o_irq_pulse,
  input wire logic              o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_rd_status;
    o_pready && !i_pwrite && (i_paddr == 'h4 || i_paddr == 'h8);
  endsequence
  chk_ready_after_setup:
    assert property (s_setup |=> o_pready) else $error("no ready");
  chk_ready_one_cycle:
    assert property (o_pready |=> !o_pready) else $error("ready long");
  chk_err_with_ready:
    assert property (o_pslverr |-> o_pready) else $error("lone slverr");
  chk_pulse_sets_level:
    assert property (o_irq_pulse |-> o_irq) else $error("pulse no irq");
  chk_rise_has_pulse:
    assert property ($rose(o_irq) |-> o_irq_pulse) else $error("no pulse");
  chk_pulse_needs_wait:
    assert property (o_irq_pulse |-> $past(i_ext_wait_in, 3))
      else $error("pulse without wait");
  chk_clear_needs_write:
    assert property ($fell(o_irq) |-> $past(i_psel && i_pwrite)
      || $past(i_psel && i_pwrite, 2)) else $error("irq fell alone");
  chk_reserved_zero:
    assert property (s_rd_status |-> (o_prdata & ~32'h5) == 32'h0)
      else $error("reserved bits set");
endmodule
bind amir_irq_mask amir_irq_mask_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// [tb/amir_cpu_intc.sv]
// CPU interrupt controller model counting pulses
`timescale 1ns/1ps
module amir_cpu_intc (
  input  wire       i_ref_clk,
  input  wire       i_rst_n,
  input  wire       i_irq_pulse,
  output reg  [7:0] o_count
);
  always @(posedge i_ref_clk) begin
    if (!i_rst_n)
      o_count <= 8'h00;
    else if (i_irq_pulse)
      o_count <= o_count + 8'h01;
  end
endmodule

// [tb/amir_irq_mask_tb_top.sv]
// Self-checking bench of the interrupt mask block
`timescale 1ns/1ps
`include "amir_map.vh"
module amir_irq_mask_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wait_in = 1'b0;
  logic        irq_pulse;
  logic        irq;
  logic [7:0]  cnt;
  logic [31:0] q;
  logic [31:0] m;
  logic        err;
  int          n_errors = 0;
  int          total_checks = 0;
  always #5 clk = ~clk;
  amir_irq_mask amir_irq_mask_inst (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_ext_wait_in(wait_in),
    .o_irq_pulse(irq_pulse), .o_irq(irq));
  amir_cpu_intc amir_cpu_intc_inst (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_irq_pulse(irq_pulse), .o_count(cnt));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_mask(input logic [2:0] r, e);
    return {29'h0, r & e & `AMIR_EVT_MASK};
  endfunction
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    // Ready looked at mid-cycle, where the registered answer has settled
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    if (n >= 20) begin
      n_errors++;
      conclude();
    end
    // Release only after the edge that samples the ready high
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic pin(input logic [31:0] hi);
    @(posedge clk);
    wait_in <= 1'b1;
    repeat (hi) @(posedge clk);
    wait_in <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    m = 32'd4 + {28'h0, lfsr(32'h9ca7e4be) & 32'hf};
    apb(0, `AMIR_OFS_MASKED, 0);
    check(q, 0);
    apb(1, `AMIR_OFS_WAIT_CFG, m);
    pin(2);
    apb(0, `AMIR_OFS_RAW, 0);
    check(q, 4);
    apb(0, `AMIR_OFS_MASKED, 0);
    check(q, exp_mask(3'h4, 3'h0));
    check({24'h0, cnt}, 0);
    $display("disabled event done");
    apb(1, `AMIR_OFS_RAW, 4);
    apb(1, `AMIR_OFS_EN_SET, 4);
    apb(0, `AMIR_OFS_EN_CLR, 0);
    check(q, 4);
    pin(2);
    apb(0, `AMIR_OFS_MASKED, 0);
    check(q, exp_mask(3'h4, 3'h4));
    check({24'h0, cnt}, 1);
    apb(1, `AMIR_OFS_MASKED, 0);
    apb(0, `AMIR_OFS_MASKED, 0);
    check(q, 4);
    apb(1, `AMIR_OFS_MASKED, 4);
    apb(0, `AMIR_OFS_RAW, 0);
    check(q, 0);
    check({31'h0, irq}, 0);
    $display("wait rise done");
    apb(1, `AMIR_OFS_EN_SET, 1);
    apb(1, `AMIR_OFS_EN_SET, 0);
    apb(0, `AMIR_OFS_EN_SET, 0);
    check(q, 5);
    pin(m + 8);
    apb(0, `AMIR_OFS_MASKED, 0);
    check(q, exp_mask(3'h5, 3'h5));
    check({24'h0, cnt}, 3);
    apb(1, `AMIR_OFS_RAW, 5);
    apb(0, `AMIR_OFS_MASKED, 0);
    check(q, 0);
    $display("timeout done");
    apb(1, `AMIR_OFS_EN_CLR, 4);
    apb(0, `AMIR_OFS_EN_SET, 0);
    check(q, 1);
    pin(2);
    apb(0, `AMIR_OFS_MASKED, 0);
    check(q, 0);
    apb(0, 12'h0f0, 0);
    check({31'h0, err}, 1);
    $display("disable and unmapped done");
    conclude();
  end
endmodule
